// ==== dv/lvds_pixel_stream_encoder_tb_top.sv ====
// Self-checking bench for the pixel stream encoder.
// Assumes a bus master, a pixel source and a receive model.
`timescale 1ns/100ps
module lvds_pixel_stream_encoder_tb_top;
    import lvds_enc_pkg::*;
    logic i_core_clk, i_rst_n, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
    logic [7:0] i_awaddr, i_araddr;
    logic [31:0] i_wdata, o_rdata, rd;
    logic [3:0] i_wstrb;
    logic i_pix_clk, i_line_valid_flag, i_frame_valid_flag, i_stereo_mismatch;
    logic [9:0] i_pix_data, i_slave_pix_data;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, rx_valid;
    logic [1:0] o_bresp, o_rresp, rr, rx_beats, cur_bin;
    logic [5:0] o_serial_data_outputs;
    logic o_serial_data_oe, o_shift_clock_outputs, o_shift_clock_oe, o_error_pin, o_irq;
    logic [17:0] rx_pkt;
    logic [19:0] rx_q[$];
    logic [9:0] e[$];
    int fail_count = 0;
    int compares = 0;
    // Power rows: {power-down value, data enable, clock enable}
    localparam logic [4:0] PWR_ROWS [8] = '{5'h03, 5'h0B, 5'h12, 5'h1A, 5'h04, 5'h0C, 5'h14, 5'h1C};
    wire [5:0] lanes_w = o_serial_data_oe ? o_serial_data_outputs : 6'bzzzzzz;
    wire sclk_w = o_shift_clock_oe ? o_shift_clock_outputs : 1'bz;

    lvds_pixel_stream_encoder u_lvds_pixel_stream_encoder (
        .i_core_clk, .i_rst_n, .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb, .i_wvalid,
        .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata,
        .o_rresp, .o_rvalid, .i_rready, .i_pix_clk, .i_pix_data, .i_slave_pix_data,
        .i_line_valid_flag, .i_frame_valid_flag, .i_stereo_mismatch, .o_serial_data_outputs,
        .o_serial_data_oe, .o_shift_clock_outputs, .o_shift_clock_oe, .o_error_pin, .o_irq);
    lvds_rx_model u_lvds_rx_model (
        .i_core_clk, .i_rst_n, .i_lanes(lanes_w), .i_sclk(sclk_w),
        .i_bin(cur_bin), .o_pkt(rx_pkt), .o_beats(rx_beats), .o_pkt_valid(rx_valid),
        .o_line_active());

    initial
    begin
        i_core_clk = 1'b0;
        forever #10 i_core_clk = ~i_core_clk;
    end
    always @(posedge i_core_clk)
        if (rx_valid)
            rx_q.push_back({rx_beats, rx_pkt});

    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[ERR] %0t got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("Counts: %0d compares, %0d fails", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic expire(input string what);
        fail_count++;
        $display("[ERR] %0t %s timed out", $time, what);
        report_and_stop();
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        bit done;
        done = 0;
        @(posedge i_core_clk);
        i_awaddr <= a;
        i_wdata <= d;
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        i_bready <= 1'b1;
        for (int n = 0; n < 50 && !done; n++)
        begin
            @(posedge i_core_clk);
            if (o_awready)
                i_awvalid <= 1'b0;
            if (o_wready)
                i_wvalid <= 1'b0;
            if (o_bvalid)
            begin
                r = o_bresp;
                i_bready <= 1'b0;
                done = 1;
            end
        end
        if (!done)
            expire("write");
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        bit done;
        done = 0;
        @(posedge i_core_clk);
        i_araddr <= a;
        i_arvalid <= 1'b1;
        i_rready <= 1'b1;
        for (int n = 0; n < 50 && !done; n++)
        begin
            @(posedge i_core_clk);
            if (o_arready)
                i_arvalid <= 1'b0;
            if (o_rvalid)
            begin
                d = o_rdata;
                r = o_rresp;
                i_rready <= 1'b0;
                done = 1;
            end
        end
        if (!done)
            expire("read");
    endtask
    // One pixel slot: inputs change after the fall, sampled on the rise
    task automatic tick(input logic fv, input logic lv, input logic [9:0] p, input logic [9:0] s);
        i_frame_valid_flag <= fv;
        i_line_valid_flag <= lv;
        i_pix_data <= p;
        i_slave_pix_data <= s;
        #80 i_pix_clk <= 1'b1;
        #80 i_pix_clk <= 1'b0;
    endtask
    task automatic rep(input logic fv, input logic lv, input logic [9:0] p, input int cnt);
        repeat (cnt) tick(fv, lv, p, p);
    endtask
    task automatic frame(input int n, input logic [9:0] a, b, c, d);
        rx_q.delete();
        #7;
        rep(1'b0, 1'b0, 10'h155, 3 * n);
        rep(1'b1, 1'b0, 10'h155, 2 * n);
        rep(1'b1, 1'b1, a, n);
        rep(1'b1, 1'b1, b, n);
        rep(1'b1, 1'b1, c, n);
        rep(1'b1, 1'b1, d, n);
        rep(1'b1, 1'b0, 10'h155, 2 * n);
        rep(1'b0, 1'b0, 10'h155, 4 * n);
    endtask
    // Finds the first packet carrying e[0], then compares the run that follows
    task automatic check_seq;
        int k;
        k = -1;
        foreach (rx_q[i])
            if (k < 0 && rx_q[i][10:1] === e[0])
                k = i;
        if (k < 0 || k + e.size() > rx_q.size())
            check(34'h0, 34'h1);
        else
            foreach (e[j])
                check(rx_q[k + j], {8'h80, 1'b0, e[j], 1'b1});
    endtask

    initial
    begin
        {i_rst_n, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_pix_clk} = 7'h00;
        {i_line_valid_flag, i_frame_valid_flag, i_stereo_mismatch} = 3'h0;
        {i_awaddr, i_araddr, i_wdata, i_pix_data, i_slave_pix_data} = 68'h0;
        i_wstrb = 4'hF;
        cur_bin = 2'h0;
        repeat (3) @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        // Walk all eight power-down settings and check both enables after each write
        foreach (PWR_ROWS[i])
        begin
            axi_wr(ADDR_PWR, {29'h0, PWR_ROWS[i][4:2]}, rr);
            repeat (4) @(posedge i_core_clk);
            check(o_serial_data_oe, PWR_ROWS[i][1]);
            check(o_shift_clock_oe, PWR_ROWS[i][0]);
        end
        $display("power done");
        axi_wr(ADDR_PWR, 32'h0, rr);
        axi_wr(ADDR_CTRL, 32'h1, rr);
        frame(1, 10'h000, 10'h003, 10'h004, 10'h3FF);
        e = '{10'h000, 10'h155, 10'h001, 10'h004, 10'h004, 10'h004, 10'h3FF, 10'h002, 10'h155, 10'h003};
        check_seq();
        axi_rd(ADDR_STAT, rd, rr);
        check(rd, 32'h3);
        check(o_irq, 1'b0);
        axi_wr(ADDR_MASK, 32'h2, rr);
        repeat (3) @(posedge i_core_clk);
        check(o_irq, 1'b1);
        axi_wr(ADDR_STAT, 32'h2, rr);
        repeat (3) @(posedge i_core_clk);
        check(o_irq, 1'b0);
        axi_rd(ADDR_STAT, rd, rr);
        check(rd, 32'h1);
        $display("frame done");
        for (int b = 1; b <= 2; b++)
        begin
            cur_bin = (b == 1) ? BIN_2 : BIN_4;
            axi_wr(ADDR_CTRL, {28'h0, cur_bin, 2'b01}, rr);
            frame(2 * b, 10'h100, 10'h200, 10'h300, 10'h3FF);
            e.delete();
            for (int v = 1; v <= 4; v++)
                repeat (2 * b) e.push_back((v == 4) ? 10'h3FF : 10'(v * 256));
            check_seq();
        end
        $display("binning done");
        cur_bin = 2'h0;
        axi_wr(ADDR_CTRL, 32'h0, rr);
        rx_q.delete();
        #7;
        rep(1'b1, 1'b1, 10'h2A8, 6);
        repeat (12) @(posedge i_core_clk);
        check(rx_q[$], {8'h80, 1'b0, 1'b1, 1'b1, 8'hAA, 1'b1});
        axi_wr(ADDR_CTRL, 32'h2, rr);
        rx_q.delete();
        #7;
        repeat (6) tick(1'b0, 1'b0, 10'h2A8, 10'h154);
        repeat (12) @(posedge i_core_clk);
        check(rx_q[$], {2'h3, 1'b0, 8'h55, 8'hAA, 1'b1});
        i_stereo_mismatch <= 1'b1;
        repeat (6) @(posedge i_core_clk);
        check(o_error_pin, 1'b1);
        axi_wr(ADDR_CTRL, 32'h0, rr);
        repeat (6) @(posedge i_core_clk);
        check(o_error_pin, 1'b0);
        $display("modes done");
        axi_rd(8'h14, rd, rr);
        check({rd, rr}, {32'h0, RESP_SLVERR});
        axi_wr(8'h14, 32'h1, rr);
        check(rr, RESP_SLVERR);
        axi_rd(8'h02, rd, rr);
        check(rr, RESP_SLVERR);
        i_rst_n <= 1'b0;
        repeat (3) @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        check({o_serial_data_oe, o_shift_clock_oe, o_irq}, 3'h0);
        axi_rd(ADDR_CTRL, rd, rr);
        check(rd, {28'h0, CTRL_RESET});
        axi_rd(ADDR_PWR, rd, rr);
        check(rd, {29'h0, PWR_RESET});
        axi_rd(ADDR_MASK, rd, rr);
        check({rd, rr}, {32'h0, RESP_OKAY});
        $display("bus and reset done");
        report_and_stop();
    end
endmodule

// ==== dv/lvds_rx_model.sv ====
// Receive model: deserializes lanes on shift clock rises, frames by idle gap.
// Assumes lanes float when released.
`timescale 1ns/100ps
module lvds_rx_model
    import lvds_enc_pkg::*;
#(
    parameter int LANES = 6
)
(
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // Serial side
    input wire logic [LANES-1:0] i_lanes,
    input wire logic i_sclk,
    input wire logic [1:0] i_bin,
    // Recovered packets
    output logic [17:0] o_pkt,
    output logic [1:0] o_beats,
    output logic o_pkt_valid,
    output logic o_line_active
);
    logic sclk_q;
    logic low_q;
    logic [1:0] beat;
    logic [1:0] sub_cnt;
    logic [17:0] acc;
    // Beat capture on each shift clock rise, packet closed after two idle cycles
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            sclk_q <= 1'b0;
            low_q <= 1'b0;
            beat <= 2'h0;
            acc <= 18'h00000;
            o_pkt_valid <= 1'b0;
        end
        else
        begin
            sclk_q <= (i_sclk === 1'b1);
            o_pkt_valid <= 1'b0;
            if (i_sclk === 1'b1)
            begin
                low_q <= 1'b0;
                if (!sclk_q)
                begin
                    acc <= acc | (18'(i_lanes) << (int'(beat) * LANES));
                    beat <= beat + 2'h1;
                end
            end
            else if (beat != 2'h0)
            begin
                low_q <= 1'b1;
                if (low_q)
                begin
                    o_pkt <= acc;
                    o_beats <= beat;
                    o_pkt_valid <= 1'b1;
                    acc <= 18'h00000;
                    beat <= 2'h0;
                end
            end
        end
    end
    // Keep one packet in 2 or 4 when binned; rebuild line valid from markers
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            sub_cnt <= 2'h0;
            o_line_active <= 1'b0;
        end
        else if (o_pkt_valid)
        begin
            sub_cnt <= (i_bin == BIN_4) ? sub_cnt + 2'h1 : {1'b0, (i_bin == BIN_2) & ~sub_cnt[0]};
            if (sub_cnt == 2'h0 && o_pkt[10:1] == MK_LS)
                o_line_active <= 1'b1;
            if (sub_cnt == 2'h0 && o_pkt[10:1] == MK_LE)
                o_line_active <= 1'b0;
        end
    end
endmodule

// ==== verilog/lvds_enc_pkg.sv ====
// Constants and types for the serial pixel stream encoder.
// Assumes an AXI4-Lite master with 32-bit data on the core clock.
package lvds_enc_pkg;
    // Register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_PWR = 8'h04;
    localparam logic [7:0] ADDR_STAT = 8'h08;
    localparam logic [7:0] ADDR_MASK = 8'h0C;
    localparam logic [7:0] ADDR_STATE = 8'h10;
    // Control fields
    localparam int CTRL_TEN_BIT = 0;
    localparam int CTRL_STEREO = 1;
    localparam int CTRL_BIN_LO = 2;
    localparam logic [3:0] CTRL_RESET = 4'h0;
    // Power-down fields, serial block powered down after reset
    localparam int PWR_GLOBAL = 0;
    localparam int PWR_DATA = 1;
    localparam int PWR_CLK = 2;
    localparam logic [2:0] PWR_RESET = 3'h1;
    // Event bits
    localparam int EV_FRAME_START = 0;
    localparam int EV_FRAME_END = 1;
    localparam int EV_OVERRUN = 2;
    localparam int EV_W = 3;
    // Column bin select codes and last repeat index per code
    localparam logic [1:0] BIN_2 = 2'h1;
    localparam logic [1:0] BIN_4 = 2'h2;
    localparam logic [1:0] REP_LAST_2 = 2'h1;
    localparam logic [1:0] REP_LAST_4 = 2'h3;
    // Reserved marker words and substitute value
    localparam logic [9:0] MK_FS = 10'h000;
    localparam logic [9:0] MK_LS = 10'h001;
    localparam logic [9:0] MK_LE = 10'h002;
    localparam logic [9:0] MK_FE = 10'h003;
    localparam logic [9:0] PIX_SUBST = 10'h004;
    // Packet framing
    localparam int PKT_SA_BITS = 12;
    localparam int PKT_ST_BITS = 18;
    localparam logic BIT_START = 1'b1;
    localparam logic BIT_STOP = 1'b0;
    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic fv;
        logic lv;
        logic [9:0] pix;
        logic [9:0] slave;
    } pix_sample_s;

    typedef enum logic {SER_IDLE, SER_SHIFT} ser_state_e;
endpackage

// ==== verilog/lvds_pixel_stream_encoder.sv ====
// Serial pixel stream encoder: markers, substitution, binning repeat,
// packet serializer with power-down enables. Pixel link is sampled
// on the core clock after synchronisers; registers over AXI4-Lite.
// Notes on behaviour
// (R1) Word 0 precedes frame valid rise; word 3 follows its fall.
// (R2) Word 1 precedes line valid rise; word 2 follows its fall.
// (R3) Column binning keeps the serial packet size unchanged.
// (R4) Bin 2 emits each pixel twice back to back.
// (R5) Bin 4 emits each pixel four times back to back.
// (R6) Receiver undersamples, one pixel every 2 or 4 packets.
// (R7) Pixel values 0 to 3 are sent as 4.
// (R8) Data outputs float while global power-down is set.
// (R9) Shift clock drives only with global and clock power-down clear.
// (R10) Error pin stays low outside stereo mode.
// (R11) Software may keep the serial block powered down when unused.
// (R12) 8-bit packet: start, pixel 9:2, line, frame, stop.
// (R13) 10-bit packet: start, pixel 9:0, stop.
// (R14) Stereo packet of 18 bits: start, master byte, slave byte, stop.
// (R15) Receiver rebuilds line valid from line markers.
// (R16) Substitution touches image pixels, never marker words.
// (R17) Power-down changes reach enables only at packet boundaries.
`timescale 1ns/100ps
module lvds_pixel_stream_encoder
    import lvds_enc_pkg::*;
#(
    parameter int LANES = 6
)
(
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // AXI4-Lite slave
    input wire logic [7:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [7:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    // Pixel link
    input wire logic i_pix_clk,
    input wire logic [9:0] i_pix_data,
    input wire logic [9:0] i_slave_pix_data,
    input wire logic i_line_valid_flag,
    input wire logic i_frame_valid_flag,
    input wire logic i_stereo_mismatch,
    // Serial outputs
    output logic [LANES-1:0] o_serial_data_outputs,
    output logic o_serial_data_oe,
    output logic o_shift_clock_outputs,
    output logic o_shift_clock_oe,
    output logic o_error_pin,
    output logic o_irq
);
    localparam logic [2:0] BEATS_SA = 3'((PKT_SA_BITS + LANES - 1) / LANES);
    localparam logic [2:0] BEATS_ST = 3'((PKT_ST_BITS + LANES - 1) / LANES);

    logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
    logic aw_full_reg, w_full_reg;
    logic [7:0] awaddr_reg;
    logic [31:0] wdata_reg, rdata_reg;
    logic [3:0] wstrb_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [3:0] ctrl_reg;
    logic [2:0] pwr_reg;
    logic [EV_W-1:0] stat_reg, mask_reg, ev;
    logic irq_reg, err_reg;
    logic clk_s1_reg, clk_s2_reg, clk_d_reg, mm_s1_reg, mm_s2_reg;
    pix_sample_s smp_s1_reg, smp_s2_reg, cur_reg, d_reg, nxt;
    logic pp_lv_reg, pp_fv_reg, pend_fe_reg;
    logic [1:0] rep_reg, rep_last;
    logic tick, wr_en, load;
    logic [9:0] word, slave_word;
    logic [PKT_ST_BITS-1:0] pkt, sh_reg;
    logic [2:0] beats_reg;
    logic phase_reg, sclk_reg, doe_reg, coe_reg;
    logic [LANES-1:0] sdata_reg;
    ser_state_e state_reg;

    assign o_awready = awready_reg;
    assign o_wready = wready_reg;
    assign o_bvalid = bvalid_reg;
    assign o_bresp = bresp_reg;
    assign o_arready = arready_reg;
    assign o_rvalid = rvalid_reg;
    assign o_rdata = rdata_reg;
    assign o_rresp = rresp_reg;
    assign o_irq = irq_reg;
    assign o_error_pin = err_reg;
    assign o_serial_data_outputs = sdata_reg;
    assign o_serial_data_oe = doe_reg;
    assign o_shift_clock_outputs = sclk_reg;
    assign o_shift_clock_oe = coe_reg;

    // Bus write channel
    assign wr_en = aw_full_reg && w_full_reg && !bvalid_reg;
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            awaddr_reg <= 8'h00;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
        end
        else
        begin
            if (i_awvalid && awready_reg)
            begin
                awaddr_reg <= i_awaddr;
                aw_full_reg <= 1'b1;
                awready_reg <= 1'b0;
            end
            if (i_wvalid && wready_reg)
            begin
                wdata_reg <= i_wdata;
                wstrb_reg <= i_wstrb;
                w_full_reg <= 1'b1;
                wready_reg <= 1'b0;
            end
            if (wr_en)
            begin
                aw_full_reg <= 1'b0;
                w_full_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg <= (awaddr_reg > ADDR_STATE || awaddr_reg[1:0] != 2'h0)
                    ? RESP_SLVERR : RESP_OKAY;
            end
            if (bvalid_reg && i_bready)
            begin
                bvalid_reg <= 1'b0;
                awready_reg <= 1'b1;
                wready_reg <= 1'b1;
            end
        end
    end

    // Register file; status is write-one-to-clear, a new event wins
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            ctrl_reg <= CTRL_RESET;
            pwr_reg <= PWR_RESET;
            mask_reg <= '0;
            stat_reg <= '0;
            irq_reg <= 1'b0;
        end
        else
        begin
            if (wr_en && wstrb_reg[0] && awaddr_reg == ADDR_CTRL)
                ctrl_reg <= wdata_reg[3:0];
            if (wr_en && wstrb_reg[0] && awaddr_reg == ADDR_PWR)
                pwr_reg <= wdata_reg[2:0];
            if (wr_en && wstrb_reg[0] && awaddr_reg == ADDR_MASK)
                mask_reg <= wdata_reg[EV_W-1:0];
            if (wr_en && wstrb_reg[0] && awaddr_reg == ADDR_STAT)
                stat_reg <= (stat_reg & ~wdata_reg[EV_W-1:0]) | ev;
            else
                stat_reg <= stat_reg | ev;
            irq_reg <= |(stat_reg & mask_reg);
        end
    end

    // Bus read channel
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            arready_reg <= 1'b1;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= RESP_OKAY;
        end
        else if (i_arvalid && arready_reg)
        begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b1;
            rresp_reg <= RESP_OKAY;
            case (i_araddr)
                ADDR_CTRL: rdata_reg <= {28'h0, ctrl_reg};
                ADDR_PWR: rdata_reg <= {29'h0, pwr_reg};
                ADDR_STAT: rdata_reg <= {29'h0, stat_reg};
                ADDR_MASK: rdata_reg <= {29'h0, mask_reg};
                ADDR_STATE: rdata_reg <= {25'h0, state_reg == SER_SHIFT, coe_reg, doe_reg,
                    pend_fe_reg, err_reg, d_reg.fv, d_reg.lv};
                default:
                begin
                    rdata_reg <= 32'h0000_0000;
                    rresp_reg <= RESP_SLVERR;
                end
            endcase
        end
        else if (rvalid_reg && i_rready)
        begin
            rvalid_reg <= 1'b0;
            arready_reg <= 1'b1;
        end
    end

    // Pixel link synchronisers and edge detection
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            clk_s1_reg <= 1'b0;
            clk_s2_reg <= 1'b0;
            clk_d_reg <= 1'b0;
            mm_s1_reg <= 1'b0;
            mm_s2_reg <= 1'b0;
            smp_s1_reg <= '0;
            smp_s2_reg <= '0;
        end
        else
        begin
            clk_s1_reg <= i_pix_clk;
            clk_s2_reg <= clk_s1_reg;
            clk_d_reg <= clk_s2_reg;
            mm_s1_reg <= i_stereo_mismatch;
            mm_s2_reg <= mm_s1_reg;
            smp_s1_reg <= {i_frame_valid_flag, i_line_valid_flag, i_pix_data, i_slave_pix_data};
            smp_s2_reg <= smp_s1_reg;
        end
    end
    assign tick = clk_s2_reg && !clk_d_reg;

    // Binning: a captured sample is held for 2 or 4 packets
    always_comb
    begin
        case (ctrl_reg[CTRL_BIN_LO +: 2])
            BIN_2: rep_last = REP_LAST_2;
            BIN_4: rep_last = REP_LAST_4;
            default: rep_last = 2'h0;
        endcase
    end
    assign nxt = (rep_reg == 2'h0) ? smp_s2_reg : cur_reg; // see (R4) (R5)

    // Marker selection on the delayed element, looking one ahead
    always_comb
    begin
        slave_word = (d_reg.slave < PIX_SUBST) ? PIX_SUBST : d_reg.slave; // see (R7)
        word = (d_reg.pix < PIX_SUBST) ? PIX_SUBST : d_reg.pix; // see (R7) (R16)
        ev = '0;
        if (!d_reg.lv)
        begin
            if (pp_lv_reg)
                word = MK_LE; // see (R2)
            else if (pend_fe_reg || (pp_fv_reg && !d_reg.fv))
                word = MK_FE; // see (R1)
            else if (d_reg.fv && nxt.lv)
                word = MK_LS; // see (R2)
            else if (!d_reg.fv && nxt.fv)
                word = MK_FS; // see (R1)
        end
        if (ctrl_reg[CTRL_STEREO] && word <= MK_FE)
            slave_word = word;
        if (tick && word == MK_FS && !d_reg.lv)
            ev[EV_FRAME_START] = 1'b1;
        if (tick && word == MK_FE && !d_reg.lv)
            ev[EV_FRAME_END] = 1'b1;
        if (tick && state_reg == SER_SHIFT)
            ev[EV_OVERRUN] = 1'b1;
        // Packet layouts
        pkt = '0;
        if (ctrl_reg[CTRL_STEREO])
            pkt = {BIT_STOP, slave_word[9:2], word[9:2], BIT_START}; // see (R14)
        else if (ctrl_reg[CTRL_TEN_BIT])
            pkt[PKT_SA_BITS-1:0] = {BIT_STOP, word, BIT_START}; // see (R13)
        else
            pkt[PKT_SA_BITS-1:0] = {BIT_STOP, d_reg.fv, d_reg.lv, word[9:2], BIT_START}; // see (R12)
    end

    // Stream pipeline, one element per pixel clock
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            rep_reg <= 2'h0;
            cur_reg <= '0;
            d_reg <= '0;
            pp_lv_reg <= 1'b0;
            pp_fv_reg <= 1'b0;
            pend_fe_reg <= 1'b0;
        end
        else if (tick)
        begin
            rep_reg <= (rep_reg >= rep_last) ? 2'h0 : rep_reg + 2'h1; // see (R3) (R4) (R5)
            cur_reg <= nxt;
            d_reg <= nxt;
            pp_lv_reg <= d_reg.lv;
            pp_fv_reg <= d_reg.fv;
            if (word == MK_FE && !d_reg.lv)
                pend_fe_reg <= 1'b0;
            else if (pp_lv_reg && !d_reg.lv && pp_fv_reg && !d_reg.fv)
                pend_fe_reg <= 1'b1; // see (R1)
        end
    end

    // Serializer: per beat, data then a rising shift clock
    assign load = tick && state_reg == SER_IDLE;
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            state_reg <= SER_IDLE;
            sh_reg <= '0;
            beats_reg <= 3'h0;
            phase_reg <= 1'b0;
            sclk_reg <= 1'b0;
            sdata_reg <= '0;
        end
        else
        begin
            case (state_reg)
                SER_IDLE:
                begin
                    sclk_reg <= 1'b0;
                    if (load)
                    begin
                        sh_reg <= pkt;
                        beats_reg <= ctrl_reg[CTRL_STEREO] ? BEATS_ST : BEATS_SA; // see (R3)
                        phase_reg <= 1'b0;
                        state_reg <= SER_SHIFT;
                    end
                end
                SER_SHIFT:
                begin
                    phase_reg <= !phase_reg;
                    if (!phase_reg)
                    begin
                        sdata_reg <= sh_reg[LANES-1:0];
                        sclk_reg <= 1'b0;
                    end
                    else
                    begin
                        sclk_reg <= 1'b1;
                        sh_reg <= sh_reg >> LANES;
                        beats_reg <= beats_reg - 3'h1;
                        if (beats_reg == 3'h1)
                            state_reg <= SER_IDLE;
                    end
                end
                default: state_reg <= SER_IDLE;
            endcase
        end
    end

    // Output enables follow power-down only between packets
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            doe_reg <= 1'b0;
            coe_reg <= 1'b0;
            err_reg <= 1'b0;
        end
        else
        begin
            if (state_reg == SER_IDLE)
            begin
                doe_reg <= !pwr_reg[PWR_GLOBAL]; // see (R8) (R17)
                coe_reg <= !pwr_reg[PWR_GLOBAL] && !pwr_reg[PWR_CLK]; // see (R9) (R17)
            end
            err_reg <= ctrl_reg[CTRL_STEREO] && mm_s2_reg; // see (R10)
        end
    end

    a_subst_floor: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see (R7)
        load && d_reg.lv |-> word >= PIX_SUBST) else $error("low pixel not substituted");
    a_fs_marker: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see (R1)
        tick && !d_reg.fv && !d_reg.lv && nxt.fv && !pp_lv_reg && !pend_fe_reg && !pp_fv_reg
        |-> word == MK_FS) else $error("frame start marker missing");
    a_fe_marker: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see (R1)
        tick && pp_fv_reg && !d_reg.fv && !pp_lv_reg && !d_reg.lv |-> word == MK_FE)
        else $error("frame end marker missing");
    a_le_marker: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see (R2)
        tick && pp_lv_reg && !d_reg.lv |-> word == MK_LE) else $error("line end marker missing");
    a_bin_hold: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see (R4) (R5)
        tick && rep_reg != 2'h0 |=> $stable(cur_reg)) else $error("binned pixel not repeated");
    a_frame_bits: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see (R12)
        load && !ctrl_reg[CTRL_STEREO] |=> sh_reg[0] == BIT_START && !sh_reg[PKT_SA_BITS-1]
        && beats_reg == BEATS_SA) else $error("stand-alone packet framing wrong");
    a_data_oe: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see (R8)
        state_reg == SER_IDLE ##1 state_reg == SER_IDLE |-> doe_reg == !$past(pwr_reg[PWR_GLOBAL]))
        else $error("data enable disagrees with power-down");
    a_clk_oe: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see (R9)
        coe_reg && $past(state_reg == SER_IDLE) |-> doe_reg && $past(!pwr_reg[PWR_CLK]))
        else $error("clock enable wrong");
    a_oe_stable: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see (R17)
        state_reg == SER_SHIFT |=> $stable(doe_reg) && $stable(coe_reg))
        else $error("enable changed inside a packet");
    a_err_low: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see (R10)
        !ctrl_reg[CTRL_STEREO] ##1 !ctrl_reg[CTRL_STEREO] |-> !o_error_pin)
        else $error("error pin high outside stereo");

    c_frame_start: cover property (@(posedge i_core_clk) disable iff (!i_rst_n)
        ev[EV_FRAME_START]);
    c_bin4_run: cover property (@(posedge i_core_clk) disable iff (!i_rst_n)
        tick && rep_reg == REP_LAST_4);
    c_stereo_load: cover property (@(posedge i_core_clk) disable iff (!i_rst_n)
        load && ctrl_reg[CTRL_STEREO]);
    c_irq: cover property (@(posedge i_core_clk) disable iff (!i_rst_n) o_irq);
endmodule
